// ===== dac_trim_pkg.sv
//============================================================================
// Purpose: Shared constants for the trim calibration controller
// Assumes: Registers reached through a decoded serial-port register strobe
// Notes:   One converter sample clock drives all logic
//============================================================================
package dac_trim_pkg;

   //=========================================================================
   // Register map
   localparam logic [4:0] ADDR_CLK_STATE = 5'h0E;
   localparam logic [4:0] ADDR_CTRL      = 5'h0F;
   localparam logic [4:0] ADDR_TADDR     = 5'h10;
   localparam logic [4:0] ADDR_TDATA     = 5'h11;

   //=========================================================================
   // Control register fields
   localparam int CTRL_START_A_DONE = 7;
   localparam int CTRL_START_A_GO   = 6;
   localparam int CTRL_COPY_DONE    = 5;
   localparam int CTRL_COPY_GO      = 4;
   localparam int CTRL_TRIM_WR      = 3;
   localparam int CTRL_TRIM_RD      = 2;
   localparam int CTRL_FACTORY_RD   = 1;
   localparam int CTRL_FORCE_DEF    = 0;
   localparam logic [7:0] CTRL_LOW_MASK = 8'h0F;

   //=========================================================================
   // Clock and state register fields
   localparam int DIV_LSB   = 0;
   localparam int DIV_W     = 3;
   localparam int STATE_LSB = 4;
   localparam logic [2:0] DIV_RESET = 3'h0;

   //=========================================================================
   // Trim memory geometry and reset values
   localparam int TRIM_W = 6;
   localparam int ADDR_W = 8;
   localparam int DEPTH  = 256;
   localparam logic [5:0] TRIM_DEFAULT = 6'h3F;
   localparam logic [7:0] TADDR_RESET  = 8'h00;
   localparam logic [5:0] TDATA_RESET  = 6'h00;
   localparam logic [7:0] REG_ZERO     = 8'h00;

   typedef enum logic [1:0] {
      CAL_FORCE_DEFAULT_TRIM   = 2'h0,
      CAL_SELF    = 2'h1,
      CAL_FACTORY = 2'h2,
      CAL_USER    = 2'h3
   } cal_state_t;

   //=========================================================================
   // Timing: divider base and cycle durations at the reference sample rate
   localparam int        DIV_CNT_W     = 12;
   localparam logic [12:0] DIV_BASE    = 13'h1000;
   localparam int        REF_CLK_MHZ   = 100;
   localparam int        START_A_MS    = 100;
   localparam int        COPY_MS       = 15;
   localparam int        TICK_CNT_W    = 12;
   localparam int        START_A_TICKS = (START_A_MS * 1000 * REF_CLK_MHZ) / 4096;
   localparam int        COPY_TICKS    = (COPY_MS * 1000 * REF_CLK_MHZ) / 4096;

endpackage

// ===== dac_trim_cal.sv
//============================================================================
// Purpose: Trim memory calibration control: divider, self-cal, factory copy,
//          indirect trim access, forced defaults and calibration state
// Assumes: Serial port delivers decoded one-cycle register strobes
// Notes:   Working trim memory lives in flip-flops; factory store is outside
//----------------------------------------------------------------------------
// Overview of operation
// - State code: 00 force_default_trim (all 63), 01 self, 10 factory, 11 user.
// - Cal clock = sample clock / 4096, halved per code step, down to /32.
// - Bit 7 of control reports a finished self-calibration.
// - Writing 1 to bit 6 of control starts self-calibration.
// - Bit 5 of control reports a finished factory copy.
// - Writing 1 to bit 4 of control starts the factory-to-working copy.
// - Bit 3 writes the data register into working trim at the address.
// - Bit 2 reads working trim at the address into the data register.
// - Bit 1 reads factory trim at the address into the data register.
// - Bit 0 forces every working trim location to default, uncalibrated.
// - Force bit stays set, holding defaults, until software clears it.
// - 8-bit trim address register at 0x10, reset to zero.
// - 6-bit trim data register at 0x11, reset zero, loaded by reads.
// - Soft reset keeps trim memory, state reports uncalibrated.
// - The copy is paced by the same divided calibration clock.
// - Self-cal lasts about 100 ms at 100 MHz with divider code zero.
// - Copy lasts about 15 ms at 100 MHz with divider code zero.
//============================================================================
`timescale 1ns/100ps

module dac_trim_cal
   import dac_trim_pkg::*;
#(
   parameter int START_A_LAST = START_A_TICKS - 1,
   parameter int COPY_LAST    = COPY_TICKS - 1
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   input  wire logic                 soft_reset_i,
   // Register port
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   input  wire logic [4:0]           reg_addr_i,
   input  wire logic [7:0]           reg_wdata_i,
   output logic      [7:0]           reg_rdata_o,
   // Factory store and self-cal engine
   output logic      [ADDR_W-1:0]    nv_addr_o,
   input  wire logic [TRIM_W-1:0]    factory_data_i,
   input  wire logic [TRIM_W-1:0]    start_a_trim_i,
   // Converter trim lookup
   input  wire logic [ADDR_W-1:0]    trim_sel_i,
   output logic      [TRIM_W-1:0]    trim_value_o,
   output logic      [1:0]           cal_state_o
);

   typedef enum logic [1:0] {OP_IDLE, OP_START_A, OP_COPY} op_t;

   function automatic logic [DIV_CNT_W-1:0] div_last(input logic [DIV_W-1:0] code);
      div_last = DIV_CNT_W'((DIV_BASE >> code) - 13'h1);
   endfunction

   //=========================================================================
   // Control state
   op_t                     op_r, op_nxt;
   cal_state_t              cal_state_r, cal_state_nxt;
   logic [DIV_W-1:0]        div_r, div_nxt;
   logic [DIV_CNT_W-1:0]    div_cnt_r, div_cnt_nxt;
   logic [TICK_CNT_W-1:0]   tick_cnt_r, tick_cnt_nxt;
   logic [ADDR_W:0]         walk_r, walk_nxt;
   logic                    start_a_done_r, start_a_done_nxt;
   logic                    copy_done_r, copy_done_nxt;
   logic [3:0]              low_ctrl_r, low_ctrl_nxt;
   logic [ADDR_W-1:0]       taddr_r, taddr_nxt;
   logic [TRIM_W-1:0]       tdata_r, tdata_nxt;
   logic                    frd_pend_r, frd_pend_nxt;
   logic [7:0]              rdata_r, rdata_nxt;
   logic [TRIM_W-1:0]       trim_out_r;
   logic [TRIM_W-1:0]       mem_r [DEPTH];
   logic [TRIM_W-1:0]       mem_nxt [DEPTH];

   logic                    ctrl_wr, idle, cal_tick, low_zero, last_tick;
   logic                    user_wr, user_rd;
   logic [TRIM_W-1:0]       rd_word;

   assign idle     = (op_r == OP_IDLE);
   assign ctrl_wr  = reg_wr_i && (reg_addr_i == ADDR_CTRL) && !soft_reset_i;
   assign low_zero = ((reg_wdata_i & CTRL_LOW_MASK) == REG_ZERO);
   assign cal_tick = !idle && (div_cnt_r == div_last(div_r));
   assign last_tick = cal_tick && (tick_cnt_r == TICK_CNT_W'((op_r == OP_START_A)
                      ? START_A_LAST : COPY_LAST));
   assign user_wr  = ctrl_wr && idle && low_zero == 1'b0 && reg_wdata_i[CTRL_TRIM_WR];
   assign user_rd  = ctrl_wr && idle && reg_wdata_i[CTRL_TRIM_RD];
   assign rd_word  = mem_r[taddr_r];
   assign nv_addr_o    = idle ? taddr_r : walk_r[ADDR_W-1:0];
   assign reg_rdata_o  = rdata_r;
   assign trim_value_o = trim_out_r;
   assign cal_state_o  = cal_state_r;

   //=========================================================================
   // Control next state
   always_comb begin
      op_nxt           = op_r;
      cal_state_nxt    = cal_state_r;
      div_nxt          = div_r;
      div_cnt_nxt      = cal_tick || idle ? '0 : DIV_CNT_W'(div_cnt_r + 12'h1);
      tick_cnt_nxt     = tick_cnt_r;
      walk_nxt         = walk_r;
      start_a_done_nxt = start_a_done_r;
      copy_done_nxt    = copy_done_r;
      low_ctrl_nxt     = low_ctrl_r;
      taddr_nxt        = taddr_r;
      tdata_nxt        = tdata_r;
      frd_pend_nxt     = 1'b0;
      rdata_nxt        = rdata_r;

      if (cal_tick) begin
         tick_cnt_nxt = TICK_CNT_W'(tick_cnt_r + 12'h1);
         if (!walk_r[ADDR_W]) begin
            walk_nxt = (ADDR_W+1)'(walk_r + 9'h1);
         end
      end
      if (last_tick) begin
         op_nxt = OP_IDLE;
         if (op_r == OP_START_A) begin
            start_a_done_nxt = 1'b1;
            cal_state_nxt    = CAL_SELF;
         end else begin
            copy_done_nxt = 1'b1;
            cal_state_nxt = CAL_FACTORY;
         end
      end

      // Register writes; a control write while busy is ignored whole
      if (reg_wr_i && !soft_reset_i) begin
         unique case (reg_addr_i)
            ADDR_CLK_STATE: div_nxt = reg_wdata_i[DIV_LSB +: DIV_W];
            ADDR_TADDR:     taddr_nxt = reg_wdata_i;
            ADDR_TDATA:     tdata_nxt = reg_wdata_i[TRIM_W-1:0];
            ADDR_CTRL: begin
               if (idle) begin
                  low_ctrl_nxt = reg_wdata_i[3:0];
                  if (reg_wdata_i[CTRL_START_A_GO] && low_zero) begin
                     op_nxt           = OP_START_A;
                     start_a_done_nxt = 1'b0;
                  end else if (reg_wdata_i[CTRL_COPY_GO] && low_zero) begin
                     op_nxt        = OP_COPY;
                     copy_done_nxt = 1'b0;
                  end
                  if (op_nxt != OP_IDLE) begin
                     tick_cnt_nxt = '0;
                     walk_nxt     = '0;
                  end
                  if (user_wr) begin
                     cal_state_nxt = CAL_USER;
                  end
                  if (user_rd) begin
                     tdata_nxt = rd_word;
                  end
                  frd_pend_nxt = reg_wdata_i[CTRL_FACTORY_RD];
               end
            end
            default: ;
         endcase
      end
      if (frd_pend_r) begin
         tdata_nxt = factory_data_i;
      end
      if (low_ctrl_nxt[CTRL_FORCE_DEF]) begin
         cal_state_nxt = CAL_FORCE_DEFAULT_TRIM;
      end

      if (reg_rd_i) begin
         unique case (reg_addr_i)
            ADDR_CLK_STATE: rdata_nxt = {2'h0, cal_state_r, 1'b0, div_r};
            ADDR_CTRL:      rdata_nxt = {start_a_done_r, op_r == OP_START_A,
                                         copy_done_r, op_r == OP_COPY, low_ctrl_r};
            ADDR_TADDR:     rdata_nxt = taddr_r;
            ADDR_TDATA:     rdata_nxt = {2'h0, tdata_r};
            default:        rdata_nxt = REG_ZERO;
         endcase
      end

      // Soft reset clears control and state but spares trim contents
      if (soft_reset_i) begin
         op_nxt           = OP_IDLE;
         cal_state_nxt    = CAL_FORCE_DEFAULT_TRIM;
         div_nxt          = DIV_RESET;
         start_a_done_nxt = 1'b0;
         copy_done_nxt    = 1'b0;
         low_ctrl_nxt     = '0;
         taddr_nxt        = TADDR_RESET;
         tdata_nxt        = TDATA_RESET;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         op_r           <= OP_IDLE;
         cal_state_r    <= CAL_FORCE_DEFAULT_TRIM;
         div_r          <= DIV_RESET;
         div_cnt_r      <= '0;
         tick_cnt_r     <= '0;
         walk_r         <= '0;
         start_a_done_r <= 1'b0;
         copy_done_r    <= 1'b0;
         low_ctrl_r     <= '0;
         taddr_r        <= TADDR_RESET;
         tdata_r        <= TDATA_RESET;
         frd_pend_r     <= 1'b0;
         rdata_r        <= REG_ZERO;
      end else begin
         op_r           <= op_nxt;
         cal_state_r    <= cal_state_nxt;
         div_r          <= div_nxt;
         div_cnt_r      <= div_cnt_nxt;
         tick_cnt_r     <= tick_cnt_nxt;
         walk_r         <= walk_nxt;
         start_a_done_r <= start_a_done_nxt;
         copy_done_r    <= copy_done_nxt;
         low_ctrl_r     <= low_ctrl_nxt;
         taddr_r        <= taddr_nxt;
         tdata_r        <= tdata_nxt;
         frd_pend_r     <= frd_pend_nxt;
         rdata_r        <= rdata_nxt;
      end
   end

   //=========================================================================
   // Working trim memory; forcing defaults overrides every other writer
   always_comb begin
      mem_nxt = mem_r;
      if (cal_tick && !walk_r[ADDR_W]) begin
         mem_nxt[walk_r[ADDR_W-1:0]] = (op_r == OP_COPY) ? factory_data_i
                                                         : start_a_trim_i;
      end
      if (user_wr) begin
         mem_nxt[taddr_r] = tdata_r;
      end
      if (low_ctrl_nxt[CTRL_FORCE_DEF]) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_nxt[i] = TRIM_DEFAULT;
         end
      end
   end

   // No reset on the array: contents survive both resets by intent
   always_ff @(posedge clk_i) begin
      mem_r      <= mem_nxt;
      trim_out_r <= mem_r[trim_sel_i];
   end

   //=========================================================================
   // Checks
   logic [DIV_CNT_W:0] gap_r;
   logic               gap_seen_r;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i || idle) begin
         gap_r      <= '0;
         gap_seen_r <= 1'b0;
      end else begin
         gap_r      <= cal_tick ? (DIV_CNT_W+1)'(1) : (DIV_CNT_W+1)'(gap_r + 13'h1);
         gap_seen_r <= gap_seen_r | cal_tick;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i || soft_reset_i);

   sequence s_start_a_req;
      ctrl_wr && idle && reg_wdata_i[CTRL_START_A_GO] && low_zero;
   endsequence
   sequence s_copy_req;
      ctrl_wr && idle && !reg_wdata_i[CTRL_START_A_GO] && reg_wdata_i[CTRL_COPY_GO]
         && low_zero;
   endsequence

   a_tick_spacing: assert property (cal_tick && gap_seen_r && $stable(div_r)
      |-> gap_r == (DIV_BASE >> div_r))
      else $error("calibration tick spacing does not match divider");
   a_start_a_start: assert property (s_start_a_req
      |=> op_r == OP_START_A && !start_a_done_r && tick_cnt_r == '0)
      else $error("self-calibration did not start cleanly");
   a_copy_start: assert property (s_copy_req
      |=> op_r == OP_COPY && !copy_done_r && walk_r == '0)
      else $error("factory copy did not start cleanly");
   a_start_a_done: assert property (last_tick && op_r == OP_START_A
      |=> start_a_done_r && idle && cal_state_r == CAL_SELF)
      else $error("self-calibration completion not reported");
   a_copy_done: assert property (last_tick && op_r == OP_COPY
      |=> copy_done_r && idle && cal_state_r == CAL_FACTORY)
      else $error("copy completion not reported");
   a_force_default: assert property (low_ctrl_r[CTRL_FORCE_DEF]
      |-> rd_word == TRIM_DEFAULT && cal_state_r == CAL_FORCE_DEFAULT_TRIM)
      else $error("forced defaults not in effect");
   a_force_holds: assert property (low_ctrl_r[CTRL_FORCE_DEF] && !ctrl_wr
      |=> low_ctrl_r[CTRL_FORCE_DEF])
      else $error("force-default bit cleared itself");
   a_trim_write: assert property (user_wr && !reg_wdata_i[CTRL_FORCE_DEF]
      |=> mem_r[$past(taddr_r)] == $past(tdata_r) && cal_state_r == CAL_USER)
      else $error("trim write not stored");
   a_trim_read: assert property (user_rd && !user_wr && !reg_wdata_i[CTRL_FORCE_DEF]
      |=> tdata_r == $past(rd_word))
      else $error("trim read not loaded");
   a_soft_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      soft_reset_i |=> cal_state_r == CAL_FORCE_DEFAULT_TRIM && idle
         && (rd_word == $past(rd_word) || $past(taddr_r) != TADDR_RESET))
      else $error("soft reset state wrong");

endmodule // dac_trim_cal

// ===== tb_top.sv
//============================================================================
// Purpose: Self-checking bench for the trim calibration controller
// Assumes: Bench plays software and the factory store through the ports
// Notes:   Short tick counts keep self-cal and copy runs brief
//============================================================================
`timescale 1ns/100ps

module tb_top
   import dac_trim_pkg::*;
;
   localparam int SL = 300;
   localparam int CL = 260;

   typedef struct {
      logic [4:0] a;
      logic [7:0] w;
      logic [7:0] e;
   } row_t;

   logic             clk_i;
   logic             rst_b_i;
   logic             soft_reset_i;
   logic             reg_wr_i;
   logic             reg_rd_i;
   logic [4:0]       reg_addr_i;
   logic [7:0]       reg_wdata_i;
   logic [7:0]       reg_rdata_o;
   logic [ADDR_W-1:0] nv_addr_o;
   logic [TRIM_W-1:0] factory_data_i;
   logic [TRIM_W-1:0] start_a_trim_i;
   logic [ADDR_W-1:0] trim_sel_i;
   logic [TRIM_W-1:0] trim_value_o;
   logic [1:0]       cal_state_o;
   int               err_count;
   int               tests_run;
   int               n;
   logic [7:0]       v;
   row_t             rows [9];

   // Store models answer combinationally from nv_addr_o, the walk address when busy, the trim address when idle
   assign factory_data_i = nv_addr_o[5:0] ^ 6'h15;
   assign start_a_trim_i = ~nv_addr_o[5:0];

   dac_trim_cal #(.START_A_LAST(SL), .COPY_LAST(CL)) DUT (
      .clk_i          (clk_i),
      .rst_b_i        (rst_b_i),
      .soft_reset_i   (soft_reset_i),
      .reg_wr_i       (reg_wr_i),
      .reg_rd_i       (reg_rd_i),
      .reg_addr_i     (reg_addr_i),
      .reg_wdata_i    (reg_wdata_i),
      .reg_rdata_o    (reg_rdata_o),
      .nv_addr_o      (nv_addr_o),
      .factory_data_i (factory_data_i),
      .start_a_trim_i (start_a_trim_i),
      .trim_sel_i     (trim_sel_i),
      .trim_value_o   (trim_value_o),
      .cal_state_o    (cal_state_o)
   );

   //=========================================================================
   // Clock and watchdog
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   initial begin
      #(60000 * 4);
      err_count++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
   end

   //=========================================================================
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1 reg_wr_i = 1'b1;
      reg_addr_i  = a;
      reg_wdata_i = d;
      @(posedge clk_i);
      #1 reg_wr_i = 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #1 reg_rd_i = 1'b1;
      reg_addr_i  = a;
      @(posedge clk_i);
      #1 reg_rd_i = 1'b0;
      d = reg_rdata_o;
   endtask

   task automatic look(input logic [7:0] sel, output logic [7:0] d);
      @(posedge clk_i);
      #1 trim_sel_i = sel;
      @(posedge clk_i);
      @(posedge clk_i);
      #1 d = {2'h0, trim_value_o};
   endtask

   // Waits for a state code, counting cycles from the start write
   task automatic wait_state(input logic [1:0] s, inout int c);
      while (cal_state_o !== s && c < 40000) begin
         @(posedge clk_i);
         #1 c++;
      end
   endtask

   task automatic end_of_test();
      $display("tests_run %0d err_count %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   //=========================================================================
   // Main sequence
   initial begin
      err_count = 0;
      tests_run = 0;
      rst_b_i = 1'b0;
      soft_reset_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 5'h00;
      reg_wdata_i = 8'h00;
      trim_sel_i = 8'h00;
      rows = '{'{5'h10, 8'hA5, 8'hA5}, '{5'h10, 8'h00, 8'h00}, '{5'h11, 8'hFF, 8'h3F},
               '{5'h11, 8'h2A, 8'h2A}, '{5'h0E, 8'hFF, 8'h07}, '{5'h0E, 8'h00, 8'h00},
               '{5'h12, 8'h55, 8'h00}, '{5'h0D, 8'h33, 8'h00}, '{5'h1F, 8'hFF, 8'h00}};
      repeat (4) @(posedge clk_i);
      #1 rst_b_i = 1'b1;

      rd(5'h0E, v); check(v, 8'h00);
      rd(5'h0F, v); check(v, 8'h00);
      rd(5'h10, v); check(v, 8'h00);
      rd(5'h11, v); check(v, 8'h00);
      check({6'h00, cal_state_o}, 8'h00);
      $display("test reset done");

      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, v);
         check(v, rows[i].e);
      end
      $display("test register rows done");

      // Forced defaults, then a user word at one location
      wr(5'h0F, 8'h01);
      look(8'h05, v); check(v, 8'h3F);
      look(8'hFF, v); check(v, 8'h3F);
      rd(5'h0F, v); check(v, 8'h01);
      check({6'h00, cal_state_o}, 8'h00);
      wr(5'h10, 8'h05);
      wr(5'h11, 8'h2A);
      wr(5'h0F, 8'h08);
      look(8'h05, v); check(v, 8'h2A);
      look(8'h06, v); check(v, 8'h3F);
      check({6'h00, cal_state_o}, 8'h03);
      wr(5'h11, 8'h00);
      wr(5'h0F, 8'h04);
      rd(5'h11, v); check(v, 8'h2A);
      wr(5'h10, 8'h09);
      wr(5'h0F, 8'h02);
      repeat (2) @(posedge clk_i);
      rd(5'h11, v); check(v, 8'h1C);
      $display("test trim access done");

      // Self-cal at /32, a copy start while busy must be refused
      wr(5'h0F, 8'h00);
      wr(5'h0E, 8'h07);
      wr(5'h0F, 8'h40);
      rd(5'h0F, v); check(v & 8'hF0, 8'h40);
      wr(5'h0F, 8'h10);
      n = 4;
      wait_state(2'h1, n);
      check(8'(n >= SL * 32), 8'h01);
      check(8'(n <= (SL + 2) * 32 + 4), 8'h01);
      rd(5'h0F, v); check(v, 8'h80);
      look(8'h00, v); check(v, 8'h3F);
      look(8'hC8, v); check(v, 8'h37);
      $display("test self-cal done");

      // Copy at /64 scales with the divider
      wr(5'h0E, 8'h06);
      wr(5'h0F, 8'h10);
      rd(5'h0F, v); check(v & 8'h30, 8'h10);
      n = 2;
      wait_state(2'h2, n);
      check(8'(n >= CL * 64), 8'h01);
      check(8'(n <= (CL + 2) * 64 + 4), 8'h01);
      rd(5'h0F, v); check(v & 8'h3F, 8'h20);
      rd(5'h0E, v); check(v, 8'h26);
      look(8'h09, v); check(v, 8'h1C);
      look(8'hC8, v); check(v, 8'h1D);
      $display("test copy done");

      // Restarts clear only their own done flag; the copy is left busy
      wr(5'h0E, 8'h07);
      wr(5'h0F, 8'h40);
      rd(5'h0F, v); check(v, 8'h60);
      n = 2;
      wait_state(2'h1, n);
      rd(5'h0F, v); check(v, 8'hA0);
      wr(5'h0F, 8'h10);
      rd(5'h0F, v); check(v, 8'h90);
      $display("test restart done");

      // Soft reset keeps memory but reports uncalibrated
      @(posedge clk_i);
      #1 soft_reset_i = 1'b1;
      @(posedge clk_i);
      #1 soft_reset_i = 1'b0;
      check({6'h00, cal_state_o}, 8'h00);
      rd(5'h10, v); check(v, 8'h00);
      rd(5'h0F, v); check(v, 8'h00);
      look(8'h09, v); check(v, 8'h36);
      $display("test soft reset done");

      // Start with a low control bit set must not run
      wr(5'h0E, 8'h07);
      wr(5'h0F, 8'h42);
      repeat (40) @(posedge clk_i);
      rd(5'h0F, v); check(v & 8'h40, 8'h00);
      check({6'h00, cal_state_o}, 8'h00);
      $display("test refused start done");
      end_of_test();
   end

endmodule // tb_top
